// file: core/irq_status_pkg.sv
// shared constants for the sticky event status and interrupt block
package irq_status_pkg;

    // event count limits; the default is a neutral choice
    localparam int EVENTS_DEFAULT = 8;
    localparam int EVENTS_MAX     = 32;

    // values held after reset
    localparam logic STATUS_RESET_BIT = 1'b0;
    localparam logic MASK_RESET_BIT   = 1'b0;
    localparam logic PREV_RESET_BIT   = 1'b0;

    // open-drain line: the only level ever driven is low
    localparam logic INT_DRIVE_LEVEL  = 1'b0;
    localparam logic INT_OE_RELEASED  = 1'b0;

    // sequencing states
    typedef enum logic [0:0] {
        ST_HOLD,
        ST_RUN
    } run_state_t;

endpackage

// file: core/event_rise_detect.sv
// per-bit rising-edge detector for event condition levels
`timescale 1ns/10ps
`default_nettype none

module event_rise_detect #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             enable_in,
    // condition levels and detected edges
    input  wire logic [WIDTH-1:0] cond_in,
    output      logic [WIDTH-1:0] rise_out
);
    import irq_status_pkg::*;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_prev;

    // prev only tracks while enabled, so a level already high when
    // sequencing starts still counts as a fresh edge
    always_comb
    begin
        next_prev = enable_in ? cond_in : prev;
        rise_out  = enable_in ? (cond_in & ~prev) : '0;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            prev <= {WIDTH{PREV_RESET_BIT}};
        else
            prev <= next_prev;
    end

endmodule // event_rise_detect

`default_nettype wire

// file: core/sticky_irq_status.sv
// sticky read-to-clear event status with masked open-drain interrupt
//
// Notes on behaviour
// - reset returns all state to defaults immediately
// - nothing starts before reset is released
// - status bits stay set until read, condition gone
// - read clears bits except still-present conditions
// - status set on condition rising edge only
// - one mask bit per status bit
// - unmasked event sets status, asserts interrupt
// - masked event sets status, interrupt unchanged
// - interrupt holds until unmasked set bits read
// - persisting condition read: interrupt drops, status stays
// - interrupt is open-drain, active low
`timescale 1ns/10ps
`default_nettype none

module sticky_irq_status
#(
    parameter int EVENTS = irq_status_pkg::EVENTS_DEFAULT
) (
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // event condition levels, same clock domain
    input  wire logic [EVENTS-1:0] cond_in,
    // mask bits, 1 masks the event from the interrupt
    input  wire logic [EVENTS-1:0] mask_in,
    // status read strobe and returned value
    input  wire logic              status_read_in,
    output      logic [EVENTS-1:0] read_data_out,
    output      logic              read_valid_out,
    // live status view
    output      logic [EVENTS-1:0] status_out,
    output      logic              running_out,
    // open-drain interrupt, active low
    output      logic              int_n_out,
    output      logic              int_oe_out
);
    import irq_status_pkg::*;

    if (EVENTS < 1 || EVENTS > EVENTS_MAX)
    begin : g_bad_events
        $error("EVENTS must be between 1 and 32");
    end

    run_state_t        state;
    run_state_t        next_state;
    logic              run_en;
    logic [EVENTS-1:0] rise;

    logic [EVENTS-1:0] status;
    logic [EVENTS-1:0] next_status;
    logic [EVENTS-1:0] unread;
    logic [EVENTS-1:0] next_unread;
    logic [EVENTS-1:0] mask;
    logic [EVENTS-1:0] next_mask;
    logic [EVENTS-1:0] next_read_data;
    logic              next_read_valid;
    logic              next_int_oe;
    logic              read_ok;

    // ---------------------------------------------------------------
    // sequencing: one hold cycle after reset release, then run
    // the hold keeps a read racing the reset release from being taken
    // ---------------------------------------------------------------
    always_comb
    begin
        case (state)
            ST_HOLD: next_state = ST_RUN;
            ST_RUN:  next_state = ST_RUN;
            default: next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= ST_HOLD;
        else
            state <= next_state;
    end

    assign run_en  = (state == ST_RUN);
    assign read_ok = run_en && status_read_in;

    event_rise_detect #(
        .WIDTH     (EVENTS)
    ) u_rise (
        .ref_clk_in(ref_clk_in),
        .rst_in    (rst_in),
        .enable_in (run_en),
        .cond_in   (cond_in),
        .rise_out  (rise)
    );

    // ---------------------------------------------------------------
    // status, unread tracking and interrupt
    // unread marks bits whose set has not yet been read; the
    // interrupt follows unread, not status, so a persisting
    // condition keeps status set without holding the line low
    // ---------------------------------------------------------------
    always_comb
    begin
        // a fresh edge in the read cycle wins over the clear
        // cond_in of the read cycle decides which bits survive
        next_status = status | rise;
        next_unread = unread | rise;
        if (read_ok)
        begin
            next_status = (status & cond_in) | rise;
            next_unread = rise;
        end
        next_mask       = mask_in;
        next_read_data  = read_ok ? status : read_data_out;
        next_read_valid = read_ok;
        // masked bits never pull the line; unmasking later does
        next_int_oe = |(next_unread & ~next_mask);
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status         <= {EVENTS{STATUS_RESET_BIT}};
            unread         <= {EVENTS{STATUS_RESET_BIT}};
            mask           <= {EVENTS{MASK_RESET_BIT}};
            read_data_out  <= {EVENTS{STATUS_RESET_BIT}};
            read_valid_out <= 1'b0;
            int_oe_out     <= INT_OE_RELEASED;
        end
        else
        begin
            status         <= next_status;
            unread         <= next_unread;
            mask           <= next_mask;
            read_data_out  <= next_read_data;
            read_valid_out <= next_read_valid;
            int_oe_out     <= next_int_oe;
        end
    end

    // the pin value is constant low; only the enable moves
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            int_n_out <= INT_DRIVE_LEVEL;
        else
            int_n_out <= INT_DRIVE_LEVEL;
    end

    assign status_out = status;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            running_out <= 1'b0;
        else
            running_out <= (next_state == ST_RUN);
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    logic [EVENTS-1:0] cond_q;
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            cond_q <= '0;
        else
            cond_q <= cond_in;
    end

    // edge view kept apart from the detector, for the checks only
    logic [EVENTS-1:0] fresh;
    assign fresh = cond_in & ~cond_q;

    sequence s_fresh_rise;
        run_en && (fresh != '0) && running_out;
    endsequence

    sequence s_read_all_clean;
        read_ok && (rise == '0);
    endsequence

    a_int_never_high: assert property (
        int_n_out == 1'b0)
        else $error("interrupt pin value not low");

    a_reset_release: assert property (
        $fell(rst_in) |-> !int_oe_out && status == '0)
        else $error("state not default after reset");

    a_hold_no_status: assert property (
        !run_en |=> status == $past(status))
        else $error("status moved before running");

    a_rise_sets_bit: assert property (
        (run_en && (rise != '0)) |=> ((status & $past(rise)) == $past(rise)))
        else $error("edge did not set status");

    a_level_no_reset: assert property (
        (run_en && !status_read_in && rise == '0) |=> status == $past(status))
        else $error("status changed without edge or read");

    a_read_keeps_live: assert property (
        s_read_all_clean |=> status == ($past(status) & $past(cond_in)))
        else $error("read clear wrong");

    a_unmasked_irq: assert property (
        (run_en && ((rise & ~mask_in) != '0)) |=> int_oe_out)
        else $error("unmasked event did not assert interrupt");

    a_read_drops_irq: assert property (
        s_read_all_clean |=> !int_oe_out ##1 (!int_oe_out || $past(rise) != '0))
        else $error("interrupt stayed after full read");

    a_irq_holds: assert property (
        int_oe_out && !status_read_in && $stable(mask_in) |=> int_oe_out)
        else $error("interrupt dropped without read");

    a_masked_quiet: assert property (
        (run_en && !int_oe_out && (rise & ~mask_in) == '0
         && (unread & ~mask_in) == '0 && $stable(mask_in)) |=> !int_oe_out)
        else $error("masked event asserted interrupt");

    a_read_data: assert property (
        read_ok |=> read_valid_out ##0 read_data_out == $past(status))
        else $error("read data not prior status");

    // ---------------------------------------------------------------
    // further checks, reset and sequencing
    // ---------------------------------------------------------------
    sequence s_pending_unmasked;
        run_en && !status_read_in && ((unread & ~mask_in) != '0);
    endsequence

    a_reset_idle: assert property (
        $fell(rst_in) |-> !running_out && !read_valid_out
                          && read_data_out == '0)
        else $error("outputs not idle after reset");

    a_hold_one_cycle: assert property (
        !run_en |=> run_en && running_out)
        else $error("hold phase did not last one cycle");

    a_hold_no_read: assert property (
        !run_en |=> !read_valid_out)
        else $error("read answered before running");

    // status bits
    a_edge_sets_status: assert property (
        s_fresh_rise |=> ((status & $past(fresh)) == $past(fresh)))
        else $error("fresh condition edge did not set status");

    a_no_spurious_set: assert property (
        (rise == '0) |=> ((status & ~$past(status)) == '0))
        else $error("status bit set without an edge");

    a_no_silent_clear: assert property (
        !read_ok |=> ((status & $past(status)) == $past(status)))
        else $error("status bit cleared without a read");

    a_live_kept: assert property (
        read_ok |=> ((status & $past(cond_in))
                     == ($past(status) & $past(cond_in))))
        else $error("present condition lost its status bit");

    a_masked_sets_status: assert property (
        (run_en && ((rise & mask_in) != '0)) |=>
            ((status & $past(rise) & $past(mask_in))
             == ($past(rise) & $past(mask_in))))
        else $error("masked edge did not set status");

    // interrupt line
    a_pending_irq: assert property (
        s_pending_unmasked |=> int_oe_out)
        else $error("unread unmasked bit not on interrupt");

    a_mask_blocks_irq: assert property (
        (run_en && (((unread | rise) & ~mask_in) == '0)) |=> !int_oe_out)
        else $error("masked bits pulled the interrupt");

    a_read_clears_unread: assert property (
        s_read_all_clean |=> (unread == '0))
        else $error("clean read left bits pending");

    // read port
    a_valid_pulse: assert property (
        !read_ok |=> !read_valid_out)
        else $error("read valid without a read");

    a_rdata_holds: assert property (
        !read_ok |=> $stable(read_data_out))
        else $error("read data moved without a read");

endmodule // sticky_irq_status

`default_nettype wire

// file: testbench/host_model.sv
// host side: status reads and the pulled-up interrupt line
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // clock
    input  wire logic ref_clk_in,
    // device side
    input  wire logic read_valid_in,
    input  wire logic int_n_in,
    input  wire logic int_oe_in,
    output var  logic status_read_out,
    // resolved interrupt line
    output      logic int_line_out
);
    // board pull-up holds the line high while released
    assign int_line_out = int_oe_in ? int_n_in : 1'b1;

    initial status_read_out = 1'b0;

    // one-cycle read pulse, then a bounded wait for the answer
    task automatic read_status(output logic ok);
        int n;
        status_read_out = 1'b1;
        @(posedge ref_clk_in);
        #1;
        status_read_out = 1'b0;
        n = 0;
        while (read_valid_in !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        ok = read_valid_in;
    endtask
endmodule // host_model

`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the sticky status and interrupt block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, g); err_count++; end end

module testbench;
    import irq_status_pkg::*;
    localparam int N = 8;
    logic         ref_clk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic [N-1:0] cond_in = '0;
    logic [N-1:0] mask_in = '0;
    logic [N-1:0] read_data_out;
    logic [N-1:0] status_out;
    logic         status_read_in;
    logic         read_valid_out;
    logic         running_out;
    logic         int_n_out;
    logic         int_oe_out;
    logic         int_line;
    logic [N-1:0] st, pd, pv;
    logic         ok;
    int           err_count = 0;
    int           tests_run = 0;
    int           cyc = 0;

    always #4 ref_clk_in = ~ref_clk_in;

    sticky_irq_status #(.EVENTS(N)) i_sticky_irq_status (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cond_in(cond_in),
        .mask_in(mask_in), .status_read_in(status_read_in),
        .read_data_out(read_data_out), .read_valid_out(read_valid_out),
        .status_out(status_out), .running_out(running_out),
        .int_n_out(int_n_out), .int_oe_out(int_oe_out));

    host_model i_host_model (
        .ref_clk_in(ref_clk_in), .read_valid_in(read_valid_out),
        .int_n_in(int_n_out), .int_oe_in(int_oe_out),
        .status_read_out(status_read_in), .int_line_out(int_line));

    function automatic logic irq(input logic [N-1:0] p, m);
        return |(p & ~m);
    endfunction

    task automatic summarize();
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            summarize();
        end
    end

    // apply levels, let two edges pass, compare against the model
    task automatic step(input logic [N-1:0] c, m, input bit rd);
        cond_in = c;
        mask_in = m;
        repeat (2) @(posedge ref_clk_in);
        #1;
        st |= c & ~pv;
        pd |= c & ~pv;
        pv = c;
        `CHK("status", st, status_out)
        `CHK("int_oe", irq(pd, m), int_oe_out)
        `CHK("int_line", ~irq(pd, m), int_line)
        `CHK("int_n", INT_DRIVE_LEVEL, int_n_out)
        if (rd)
        begin
            i_host_model.read_status(ok);
            `CHK("valid", 1'b1, ok)
            `CHK("rdata", st, read_data_out)
            st &= c;
            pd = '0;
            `CHK("kept", st, status_out)
            `CHK("int_off", 1'b0, int_oe_out)
        end
    endtask

    initial
    begin
        void'($urandom(32'hA768));
        repeat (8) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        `CHK("hold", 1'b0, running_out)
        @(posedge ref_clk_in);
        #1;
        `CHK("run", 1'b1, running_out)
        st = '0;
        pd = '0;
        pv = '0;
        step('0, '0, 1'b1);
        step(8'hFF, 8'hFF, 1'b0);
        step(8'hFF, 8'h00, 1'b0);
        step(8'hFF, 8'h00, 1'b1);
        step(8'h0F, 8'h00, 1'b0);
        step(8'h0F, 8'h00, 1'b1);
        repeat (200) step(N'($urandom), N'($urandom), 1'($urandom));
        // reset in mid-run with every condition held high
        cond_in = 8'hFF;
        rst_in = 1'b1;
        #1;
        `CHK("rst_status", 8'h00, status_out)
        `CHK("rst_int", INT_OE_RELEASED, int_oe_out)
        `CHK("rst_valid", 1'b0, read_valid_out)
        `CHK("rst_run", 1'b0, running_out)
        repeat (2) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        // a read in the hold cycle must go unanswered
        i_host_model.read_status(ok);
        `CHK("hold_read", 1'b0, ok)
        `CHK("rst_edge", 8'hFF, status_out)
        st = '0;
        pd = '0;
        pv = '0;
        step(8'hFF, 8'h00, 1'b1);
        summarize();
    end
endmodule // testbench

`default_nettype wire
